// ### cid_decoder.sv
// Instruction decoder for bit, control, literal and table instructions
// Contract
// - Bit clear/set/toggle/test opcodes, no flags
// - Skips take one, two or three cycles
// - Conditional and unconditional relative branches
// - Long call two words; relative call
// - Absolute jump is two words, two cycles
// - Lone second word executes as no-operation
// - Top nibble 1111 is single-cycle no-op
// - Fixed control words: nop, standby, watchdog, adjust, reset
// - Single-cycle return stack push and pop
// - Interrupt and subroutine returns, two cycles
// - Literal return loads working register, two cycles
// - Literal operations by second nibble
// - Literal flag effects per operation
// - Load four-bit literal into bank select
// - Two-word pointer load of 12-bit literal
// - Table reads with four pointer modes
// - Table writes with four pointer modes
// - Port read-modify-write sources pin levels
// - Timer-zero write clears assigned prescaler
// - Taken relative branch, relative call or return adds no-op cycle
// - Access bit selects access or banked memory
`timescale 1ns/1ps
module cid_decoder
  import cid_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_nrst,
  // AXI4-Lite slave
  input  wire logic [AXI_AW-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [AXI_AW-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  // Program memory word at o_pc_addr
  input  wire logic [15:0]       i_instr,
  input  wire logic              i_instr_valid,
  output logic                   o_instr_ready,
  output logic [20:0]            o_pc_addr,
  // Datapath state
  input  wire logic [4:0]        i_status,
  input  wire logic [7:0]        i_file_data,
  input  wire logic [7:0]        i_pin_data,
  input  wire logic [20:0]       i_return_addr,
  input  wire logic              i_prescaler_assigned,
  // Decoded instruction
  output logic                   o_exec,
  output cid_op_e                o_op,
  output logic [7:0]             o_flag_mask,
  output logic [1:0]             o_cycles,
  output logic [2:0]             o_bit_pos,
  output logic [11:0]            o_file_addr,
  output logic [11:0]            o_literal,
  output logic [1:0]             o_fsr_sel,
  output logic                   o_shadow,
  output logic [1:0]             o_tbl_mode,
  output logic                   o_src_pins,
  output logic                   o_prescaler_clear,
  output logic                   o_stack_push,
  output logic                   o_stack_pop,
  output logic                   o_soft_reset,
  output logic                   o_nop_slot,
  output logic [3:0]             o_bsr
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file state
  logic        ctrl_en;
  logic [11:0] tmr_addr;
  logic [31:0] exec_count;
  logic [7:0]  aw_addr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wr_fire;
  logic        wr_hit;

  // Both address and data held, response not yet raised
  assign wr_fire = !o_awready && !o_wready && !o_bvalid;
  assign wr_hit  = (aw_addr == REG_CTRL) || (aw_addr == REG_TMR_ADDR);

  // Write channels; address and data accepted in either order
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= RESP_OKAY;
      aw_addr   <= '0;
      wdata     <= '0;
      wstrb     <= '0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_addr   <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        wdata    <= i_wdata;
        wstrb    <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        o_bresp  <= (wr_hit || aw_addr == REG_STATUS || aw_addr == REG_COUNT) ?
                    RESP_OKAY : RESP_DECERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // Writable registers; status and count are read-only
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_en  <= CTRL_EN_RST;
      tmr_addr <= TMR_ADDR_RST;
    end else if (wr_fire) begin
      if (aw_addr == REG_CTRL && wstrb[0]) begin
        ctrl_en <= wdata[CTRL_EN_BIT];
      end
      if (aw_addr == REG_TMR_ADDR) begin
        if (wstrb[0]) begin
          tmr_addr[7:0] <= wdata[7:0];
        end
        if (wstrb[1]) begin
          tmr_addr[11:8] <= wdata[11:8];
        end
      end
    end
  end

  cid_state_e state;

  // Read channel; one-cycle answer after the address is taken
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rresp   <= RESP_OKAY;
      unique case (i_araddr)
        REG_CTRL:     o_rdata <= {31'h0, ctrl_en};
        REG_STATUS:   o_rdata <= {16'h0, 2'h0, state, o_bsr, 2'h0, o_op};
        REG_COUNT:    o_rdata <= exec_count;
        REG_TMR_ADDR: o_rdata <= {20'h0, tmr_addr};
        default: begin
          o_rdata <= '0;
          o_rresp <= RESP_DECERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Opcode decode of the presented word
  cid_op_e    dec_op;
  logic [7:0] dec_mask;
  logic       dec_two;

  always_comb begin
    dec_op   = OP_OTHER;
    dec_mask = MASK_NONE;
    dec_two  = 1'b0;
    casez (i_instr)
      16'h9???: dec_op = OP_BIT_CLEAR;
      16'h8???: dec_op = OP_BIT_SET;
      16'h7???: dec_op = OP_BIT_TOGGLE;
      16'hB???: dec_op = OP_BTST_CLEAR;
      16'hA???: dec_op = OP_BTST_SET;
      16'b1110_0???_????_????: dec_op = OP_COND_BRANCH;
      16'b1101_0???_????_????: dec_op = OP_UNCOND_BRANCH;
      16'b1101_1???_????_????: dec_op = OP_REL_SUB_JUMP;
      16'b1110_110?_????_????: begin
        dec_op  = OP_LONG_CALL;
        dec_two = 1'b1;
      end
      16'hEF??: begin
        dec_op  = OP_ABS_JUMP;
        dec_two = 1'b1;
      end
      16'b1110_1110_00??_????: begin
        dec_op  = OP_POINTER_LOAD;
        dec_two = 1'b1;
      end
      16'hC???: dec_two = 1'b1;    // Byte move first word: two-word sequencing and skip length
      16'hF???: dec_op = OP_NOP;
      16'h0000: dec_op = OP_NOP;
      16'h0003: begin
        dec_op   = OP_STANDBY;
        dec_mask = MASK_PWR;
      end
      16'h0004: begin
        dec_op   = OP_WATCHDOG_CLEAR;
        dec_mask = MASK_PWR;
      end
      16'h0007: begin
        dec_op   = OP_DECIMAL_ADJUST;
        dec_mask = MASK_CARRY;
      end
      16'h00FF: begin
        dec_op   = OP_SOFT_RESET;
        dec_mask = MASK_ALL;
      end
      16'h0005: dec_op = OP_PUSH;
      16'h0006: dec_op = OP_POP;
      16'b0000_0000_0001_000?: begin
        dec_op   = OP_IRQ_RETURN;
        dec_mask = MASK_IRQ;
      end
      16'b0000_0000_0001_001?: dec_op = OP_SUB_RETURN;
      16'h0C??: dec_op = OP_LIT_RETURN;
      16'h0F??: begin
        dec_op   = OP_LIT_ADD;
        dec_mask = MASK_ARITH;
      end
      16'h08??: begin
        dec_op   = OP_LIT_SUB;
        dec_mask = MASK_ARITH;
      end
      16'h0B??: begin
        dec_op   = OP_LIT_AND;
        dec_mask = MASK_LOGIC;
      end
      16'h09??: begin
        dec_op   = OP_LIT_OR;
        dec_mask = MASK_LOGIC;
      end
      16'h0A??: begin
        dec_op   = OP_LIT_XOR;
        dec_mask = MASK_LOGIC;
      end
      16'h0D??: dec_op = OP_LIT_MULTIPLY;
      16'h0E??: dec_op = OP_LIT_MOVE;
      16'h010?: dec_op = OP_BANK_LOAD;
      16'b0000_0000_0000_10??: dec_op = OP_TABLE_READ;
      16'b0000_0000_0000_11??: dec_op = OP_TABLE_WRITE;
      default: dec_op = OP_OTHER;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand fields
  logic [11:0] eff_addr;
  logic        is_port;
  logic        bit_val;
  logic [2:0]  cc;
  logic        cond_true;
  logic [20:0] pc_inc;
  logic [20:0] tgt_short;
  logic [20:0] tgt_long;
  logic [20:0] tgt_abs;
  logic [15:0] word1;

  // Access bit 0 maps to the access bank, 1 to the banked page
  assign eff_addr = i_instr[8] ? {o_bsr, i_instr[7:0]} :
                    ((i_instr[7:0] < ACCESS_SPLIT) ? {4'h0, i_instr[7:0]} :
                                                     {ACCESS_HI_BNK, i_instr[7:0]});
  assign is_port  = (eff_addr >= PORT_LO) && (eff_addr <= PORT_HI);
  // Port bits read the pins, so inputs held low by the outside read back low
  assign bit_val  = is_port ? i_pin_data[i_instr[11:9]] :
                              i_file_data[i_instr[11:9]];

  // Condition code: flag pair selected by the upper bits, odd codes invert
  assign cc = i_instr[10:8];
  always_comb begin
    unique case (cc[2:1])
      2'h0: cond_true = i_status[ST_Z] ^ cc[0];
      2'h1: cond_true = i_status[ST_C] ^ cc[0];
      2'h2: cond_true = i_status[ST_OV] ^ cc[0];
      2'h3: cond_true = i_status[ST_N] ^ cc[0];
    endcase
  end

  // Offsets count words past the incremented PC
  assign pc_inc    = o_pc_addr + PC_STEP;
  assign tgt_short = pc_inc + {{12{i_instr[7]}}, i_instr[7:0], 1'b0};
  assign tgt_long  = pc_inc + {{9{i_instr[10]}}, i_instr[10:0], 1'b0};
  assign tgt_abs   = {i_instr[11:0], word1[7:0], 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  cid_state_e next_state;
  logic [20:0] next_pc;
  logic        take;

  assign take = i_instr_valid && o_instr_ready;

  always_comb begin
    next_state = state;
    next_pc    = o_pc_addr;
    unique case (state)
      ST_EXEC: if (take) begin
        next_pc = pc_inc;
        if (dec_two) begin
          next_state = ST_WORD2;
        end else if (dec_op == OP_COND_BRANCH && cond_true) begin
          next_pc    = tgt_short;
          next_state = ST_HOLD;
        end else if (dec_op == OP_UNCOND_BRANCH || dec_op == OP_REL_SUB_JUMP) begin
          next_pc    = tgt_long;
          next_state = ST_HOLD;
        end else if ((dec_op == OP_BTST_CLEAR && !bit_val) ||
                     (dec_op == OP_BTST_SET && bit_val)) begin
          next_state = ST_SKIP;
        end else if (dec_op == OP_IRQ_RETURN || dec_op == OP_SUB_RETURN ||
                     dec_op == OP_LIT_RETURN) begin
          next_pc    = i_return_addr;
          next_state = ST_HOLD;
        end else if (dec_op == OP_TABLE_READ || dec_op == OP_TABLE_WRITE) begin
          next_state = ST_HOLD;
        end else if (dec_op == OP_SOFT_RESET) begin
          next_pc = PC_RST;
        end
      end
      ST_WORD2: if (take) begin
        next_state = ST_EXEC;
        next_pc    = (word1[15:12] == 4'hE && word1[11:8] != 4'hE) ? tgt_abs : pc_inc;
      end
      // Skipped word: a two-word first word keeps skipping one more
      ST_SKIP: if (take) begin
        next_pc    = pc_inc;
        next_state = dec_two ? ST_SKIP : ST_EXEC;
      end
      ST_HOLD: next_state = ST_EXEC;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state         <= ST_EXEC;
      o_pc_addr     <= PC_RST;
      o_instr_ready <= 1'b0;
    end else begin
      state         <= next_state;
      o_pc_addr     <= next_pc;
      // Dead cycle of a flow change is a stall, so the fetch is not lost
      o_instr_ready <= ctrl_en && (next_state != ST_HOLD);
    end
  end

  // First word kept for the second-word cycle
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      word1 <= '0;
    end else if (take && state == ST_EXEC) begin
      word1 <= i_instr;
    end
  end

  // Bank select, loaded from the literal, cleared by software reset
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bsr <= '0;
    end else if (take && state == ST_EXEC) begin
      if (dec_op == OP_BANK_LOAD) begin
        o_bsr <= i_instr[3:0];
      end else if (dec_op == OP_SOFT_RESET) begin
        o_bsr <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Issued instruction outputs
  logic exec1;
  logic exec2;
  logic bit_wr;

  assign exec1  = take && state == ST_EXEC && !dec_two;
  assign exec2  = take && state == ST_WORD2;
  assign bit_wr = dec_op == OP_BIT_CLEAR || dec_op == OP_BIT_SET || dec_op == OP_BIT_TOGGLE;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_exec            <= 1'b0;
      o_op              <= OP_NOP;
      o_flag_mask       <= MASK_NONE;
      o_cycles          <= 2'h0;
      o_bit_pos         <= '0;
      o_file_addr       <= '0;
      o_literal         <= '0;
      o_fsr_sel         <= '0;
      o_shadow          <= 1'b0;
      o_tbl_mode        <= '0;
      o_src_pins        <= 1'b0;
      o_prescaler_clear <= 1'b0;
      o_stack_push      <= 1'b0;
      o_stack_pop       <= 1'b0;
      o_soft_reset      <= 1'b0;
      o_nop_slot        <= 1'b0;
    end else begin
      o_exec            <= exec1 || exec2;
      o_nop_slot        <= state == ST_HOLD || (take && state == ST_SKIP);
      o_src_pins        <= exec1 && bit_wr && is_port;
      o_prescaler_clear <= exec1 && bit_wr && eff_addr == tmr_addr &&
                           i_prescaler_assigned;
      o_stack_push      <= (exec1 && (dec_op == OP_PUSH || dec_op == OP_REL_SUB_JUMP)) ||
                           (exec2 && word1[15:9] == 7'b1110_110);
      o_stack_pop       <= exec1 && (dec_op == OP_POP || dec_op == OP_IRQ_RETURN ||
                                     dec_op == OP_SUB_RETURN || dec_op == OP_LIT_RETURN);
      o_soft_reset      <= exec1 && dec_op == OP_SOFT_RESET;
      if (exec1) begin
        o_op        <= dec_op;
        o_flag_mask <= dec_mask;
        o_cycles    <= (dec_op == OP_UNCOND_BRANCH || dec_op == OP_REL_SUB_JUMP ||
                        (dec_op == OP_COND_BRANCH && cond_true) ||
                        next_state == ST_HOLD) ? 2'h2 : 2'h1;
        o_bit_pos   <= i_instr[11:9];
        o_file_addr <= eff_addr;
        o_literal   <= {4'h0, i_instr[7:0]};
        o_shadow    <= i_instr[0];
        o_tbl_mode  <= i_instr[1:0];
      end else if (exec2) begin
        // Byte move pairs are out of scope here, so they must not pose as a jump
        o_op        <= (word1[15:12] != 4'hE) ? OP_OTHER :
                       (word1[11:8] == 4'hF) ? OP_ABS_JUMP :
                       (word1[11:8] == 4'hE) ? OP_POINTER_LOAD : OP_LONG_CALL;
        o_flag_mask <= MASK_NONE;
        o_cycles    <= 2'h2;
        o_literal   <= {word1[3:0], i_instr[7:0]};
        o_fsr_sel   <= word1[5:4];
        o_shadow    <= word1[8];
      end
    end
  end

  // Executed-instruction counter for software
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      exec_count <= '0;
    end else if (o_exec) begin
      exec_count <= exec_count + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  bit_op_flags_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_exec && (o_op inside {OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_TOGGLE}) |-> o_flag_mask == MASK_NONE)
    else $error("bit operation reports flag changes");

  skip_length_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    state == ST_SKIP && take && !dec_two |=> state == ST_EXEC && !o_exec && o_nop_slot)
    else $error("skip did not end after one-word instruction");

  branch_hold_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    state == ST_EXEC && take && dec_op == OP_UNCOND_BRANCH
    |=> state == ST_HOLD && !o_instr_ready ##1 state == ST_EXEC)
    else $error("taken branch lacks its no-op cycle");

  branch_target_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    state == ST_EXEC && take && dec_op == OP_COND_BRANCH && cond_true
    |=> o_pc_addr == $past(tgt_short))
    else $error("branch target wrong");

  call_two_word_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    state == ST_WORD2 && take && word1[15:9] == 7'b1110_110
    |=> state == ST_EXEC && o_exec && o_op == OP_LONG_CALL && o_cycles == 2'h2 && o_stack_push)
    else $error("long call not handled as two words");

  add_flags_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_exec && (o_op inside {OP_LIT_ADD, OP_LIT_SUB}) |-> o_flag_mask == MASK_ARITH)
    else $error("literal arithmetic flags wrong");

  bank_load_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_exec && o_op == OP_BANK_LOAD |-> o_bsr == o_literal[3:0])
    else $error("bank select not loaded");

  prescale_clear_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_prescaler_clear |-> o_exec && o_file_addr == tmr_addr)
    else $error("prescaler cleared for wrong target");

  pin_source_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_src_pins |-> o_file_addr >= PORT_LO && o_file_addr <= PORT_HI)
    else $error("pin source outside port range");

endmodule

// ### cid_pkg.sv
// Shared constants, opcodes and register map of the instruction decoder
package cid_pkg;

  // AXI4-Lite register map (byte addresses)
  localparam int          AXI_AW        = 8;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_COUNT     = 8'h08;
  localparam logic [7:0]  REG_TMR_ADDR  = 8'h0C;
  localparam int          CTRL_EN_BIT   = 0;
  localparam logic        CTRL_EN_RST   = 1'b1;
  localparam logic [11:0] TMR_ADDR_RST  = 12'hFD6;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_DECERR   = 2'b11;

  // Data memory layout used by the bit operations
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;
  localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;
  localparam logic [11:0] PORT_LO       = 12'hF80;
  localparam logic [11:0] PORT_HI       = 12'hF8F;

  // Status input field positions
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_OV = 3;
  localparam int ST_N  = 4;

  // Affected-flag mask bit positions and common masks
  localparam int FM_TO  = 5;
  localparam int FM_PD  = 6;
  localparam int FM_GIE = 7;
  localparam logic [7:0] MASK_NONE  = 8'h00;
  localparam logic [7:0] MASK_ARITH = 8'h1F;
  localparam logic [7:0] MASK_LOGIC = 8'h14;
  localparam logic [7:0] MASK_CARRY = 8'h01;
  localparam logic [7:0] MASK_PWR   = 8'h60;
  localparam logic [7:0] MASK_IRQ   = 8'h80;
  localparam logic [7:0] MASK_ALL   = 8'hFF;

  localparam logic [20:0] PC_RST  = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;

  typedef enum logic [5:0] {
    OP_NOP, OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_TOGGLE, OP_BTST_CLEAR, OP_BTST_SET,
    OP_COND_BRANCH, OP_UNCOND_BRANCH, OP_REL_SUB_JUMP, OP_LONG_CALL, OP_ABS_JUMP,
    OP_STANDBY, OP_WATCHDOG_CLEAR, OP_DECIMAL_ADJUST, OP_SOFT_RESET, OP_PUSH, OP_POP,
    OP_IRQ_RETURN, OP_SUB_RETURN, OP_LIT_RETURN, OP_LIT_ADD, OP_LIT_AND, OP_LIT_OR,
    OP_LIT_SUB, OP_LIT_XOR, OP_LIT_MULTIPLY, OP_LIT_MOVE, OP_BANK_LOAD,
    OP_POINTER_LOAD, OP_TABLE_READ, OP_TABLE_WRITE, OP_OTHER
  } cid_op_e;

  typedef enum logic [1:0] {ST_EXEC, ST_WORD2, ST_SKIP, ST_HOLD} cid_state_e;

endpackage

// ### cid_pmem.sv
// Program memory model answering the decoder's fetch port
`timescale 1ns/1ps
module cid_pmem (
  input  wire logic [20:0] i_addr,
  input  wire logic        i_stall,
  output logic [15:0]      o_instr,
  output logic             o_valid
);
  logic [15:0] mem [0:63];
  // Stalled answer shows the flipped word, so a stale read never matches
  assign o_valid = !i_stall;
  assign o_instr = i_stall ? ~mem[i_addr[6:1]] : mem[i_addr[6:1]];
endmodule

// ### tb.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
module tb;
  import cid_pkg::*;
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
  // Word, then expected {op, flag mask, pin source, prescaler clear, cycles}
  localparam logic [34:0] PROG [17] = '{
    {1'h1, 16'h0F12, OP_LIT_ADD, MASK_ARITH, 4'h1},
    {1'h1, 16'h0A33, OP_LIT_XOR, MASK_LOGIC, 4'h1},
    {1'h1, 16'h0801, OP_LIT_SUB, MASK_ARITH, 4'h1},
    {1'h1, 16'h0D02, OP_LIT_MULTIPLY, MASK_NONE, 4'h1},
    {1'h1, 16'h0E05, OP_LIT_MOVE, MASK_NONE, 4'h1},
    {1'h1, 16'h0004, OP_WATCHDOG_CLEAR, MASK_PWR, 4'h1},
    {1'h1, 16'h0007, OP_DECIMAL_ADJUST, MASK_CARRY, 4'h1},
    {1'h1, 16'h0005, OP_PUSH, MASK_NONE, 4'h1},
    {1'h1, 16'h0009, OP_TABLE_READ, MASK_NONE, 4'h2},
    {1'h1, 16'h0105, OP_BANK_LOAD, MASK_NONE, 4'h1},
    {1'h1, 16'hF123, OP_NOP, MASK_NONE, 4'h1},
    {1'h1, 16'h9A80, OP_BIT_CLEAR, MASK_NONE, 4'h9},
    {1'h1, 16'h88D6, OP_BIT_SET, MASK_NONE, 4'h5},
    {1'h1, 16'hEF10, OP_ABS_JUMP, MASK_NONE, 4'h2},
    {1'h0, 16'hF000, 18'h0},
    {1'h0, 16'h0F00, 18'h0},
    {1'h1, 16'hD7FF, OP_UNCOND_BRANCH, MASK_NONE, 4'h2}};
  logic        c = 0, n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, stl = 0;
  logic [7:0]  awa = 0, ara = 0, fd = 0, pd = 0, fm;
  logic [31:0] wd = 0, rd;
  logic [3:0]  ws = 0;
  logic [4:0]  st = 0;
  logic [1:0]  br, rr, cy;
  logic        awr, wr, bv, arr, rv, ex, sp, pcl, iv;
  logic [20:0] pca;
  logic [15:0] ins;
  logic [17:0] e;
  cid_op_e     op;
  int          fail_count = 0, samples_checked = 0, seed = 32'hb095;
  logic [17:0] q[$];
  cid_pmem pm (.i_addr(pca), .i_stall(stl), .o_instr(ins), .o_valid(iv));
  cid_decoder dut (.i_mclk(c), .i_nrst(n), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
    .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wr), .o_bresp(br), .o_bvalid(bv),
    .i_bready(bry), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rd),
    .o_rresp(rr), .o_rvalid(rv), .i_rready(rry), .i_instr(ins), .i_instr_valid(iv),
    .o_instr_ready(), .o_pc_addr(pca), .i_status(st), .i_file_data(fd), .i_pin_data(pd),
    .i_return_addr(21'h0), .i_prescaler_assigned(1'b1), .o_exec(ex), .o_op(op),
    .o_flag_mask(fm), .o_cycles(cy), .o_bit_pos(), .o_file_addr(), .o_literal(), .o_fsr_sel(),
    .o_shadow(), .o_tbl_mode(), .o_src_pins(sp), .o_prescaler_clear(pcl), .o_stack_push(),
    .o_stack_pop(), .o_soft_reset(), .o_nop_slot(), .o_bsr());
  initial forever #5 c = ~c;
  // Datapath noise and random fetch stalls keep the decode honest
  always @(posedge c) begin
    st <= 5'($random(seed));
    fd <= 8'($random(seed));
    pd <= 8'($random(seed));
    stl <= ($random(seed) & 3) == 0;
  end
  // Registers only move on rising edges, so the falling edge sees them settled
  always @(negedge c) if (ex === 1'b1 && q.size() > 0) begin
    e = q.pop_front();
    `CHK("issued", e, {op, fm, sp, pcl, cy})
  end
  // One register access; mask keeps only the read bits that are defined
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] m,
                     input logic [33:0] x);
    logic ta, tw;
    ta = 0;
    tw = !w;
    @(posedge c);
    awa <= a;
    ara <= a;
    wd <= 32'($random(seed)) & 32'hFFFFFFFE;
    ws <= 4'hF;
    awv <= w;
    wv <= w;
    arv <= !w;
    bry <= w;
    rry <= !w;
    while (!(ta && tw)) begin
      @(negedge c);
      ta = ta | (awv & awr) | (arv & arr);
      tw = tw | (wv & wr);
      @(posedge c);
      awv <= awv & !ta;
      arv <= arv & !ta;
      wv <= wv & !tw;
    end
    do @(negedge c); while ((w ? bv : rv) !== 1'b1);
    `CHK("response", x, {w ? br : rr, (w ? 32'h0 : rd) & m})
    @(posedge c);
    bry <= 0;
    rry <= 0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Blank words decode as no-ops; the word after the jump is never issued
  initial begin
    for (int i = 0; i < 64; i++) pm.mem[i] = 16'hFFFF;
    for (int i = 0; i < 17; i++) begin
      pm.mem[i] = PROG[i][33:18];
      if (PROG[i][34]) q.push_back(PROG[i][17:0]);
    end
    repeat (10) @(posedge c);
    n <= 1;
    repeat (120) @(posedge c);
    `CHK("pending", 0, q.size())
    $display("test done: instruction stream");
    axi(0, REG_STATUS, 32'h0F00, {RESP_OKAY, 32'h500});
    axi(0, REG_TMR_ADDR, 32'hFFF, {RESP_OKAY, 20'h0, TMR_ADDR_RST});
    axi(1, REG_CTRL, 32'h0, {RESP_OKAY, 32'h0});
    axi(0, REG_CTRL, 32'h1, {RESP_OKAY, 32'h0});
    axi(0, 8'h10, 32'hFFFFFFFF, {RESP_DECERR, 32'h0});
    $display("test done: register access");
    complete_run;
  end
  // Hang guard, far beyond the roughly 150 cycles the tests need
  initial begin
    #20us;
    fail_count++;
    complete_run;
  end
endmodule
